// ==== verilog/lpw_pkg.sv ====
// lpw_pkg: constants and types shared by the low-power wake controller files
// assumes nothing of its surroundings; included first in compile order
package lpw_pkg;
   // oscillator restart delay, in cycles of the restarted oscillator clock
   localparam int unsigned RESTART_DELAY_CYCLES = 4096;
   localparam int unsigned DELAY_W = 13;
   localparam logic [DELAY_W-1:0] DELAY_LAST = 13'(RESTART_DELAY_CYCLES - 1);
   // reset values of control bits
   localparam logic RST_GMASK = 1'b1;
   localparam logic RST_XMASK = 1'b1;
   localparam logic RST_STARTUP_WAIT_ON = 1'b1;
   localparam logic RST_POR_PENDING = 1'b1;
   // number of stages of the two-flop synchroniser
   localparam int unsigned SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      LPW_RUN,
      LPW_STACK,
      LPW_WAIT,
      LPW_STOP,
      LPW_RESTART,
      LPW_SERVICE
   } lpw_state_t;
endpackage

// ==== verilog/lpw_sync.sv ====
// lpw_sync: two-flop synchroniser for one pin level
// assumes the pin is asynchronous to sys_clk; resets to a chosen idle level
`timescale 1ns/1ps
`default_nettype none
module lpw_sync #(
   parameter logic IDLE = 1'b1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // level in and out
   input wire logic pin,
   output logic level
);
   logic meta;
   // first flop feeds only the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta <= IDLE;
         level <= IDLE;
      end else begin
         meta <= pin;
         level <= meta;
      end
   end
endmodule // lpw_sync
`default_nettype wire

// ==== verilog/lpw_flag.sv ====
// lpw_flag: sticky interrupt flag with enable gating
// assumes set and clear are on the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module lpw_flag (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // event, software clear and enable
   input wire logic set_evt,
   input wire logic sw_clear,
   input wire logic enable,
   // state
   output logic flag,
   output logic request
);
   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (set_evt) begin
         flag <= 1'b1;
      end else if (sw_clear) begin
         flag <= 1'b0;
      end
   end
   // request held while flag and enable both stand
   assign request = flag & enable;
endmodule // lpw_flag
`default_nettype wire

// ==== verilog/lpw_wake_ctrl.sv ====
// lpw_wake_ctrl: wait/stop low-power state control and interrupt wake logic
// assumes the cpu core raises one-cycle instruction strobes on sys_clk and
// leaves the pins asynchronous, as they pass through synchronisers here; pins are active low
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // external pins, active low
   input wire logic irq_req_n_pin,
   input wire logic nonmask_req_pin_n,
   // cpu instruction strobes and status
   input wire logic soft_trap_instr,
   input wire logic sleep_instr,
   input wire logic stop_instr,
   input wire logic stack_done,
   input wire logic service_done,
   input wire logic stop_disable,
   input wire logic [15:0] stacked_flags_addr,
   // software mask controls
   input wire logic gmask_clear,
   input wire logic gmask_set,
   input wire logic xmask_clear,
   input wire logic startup_wait_clear,
   // peripheral configuration and requests
   input wire logic watchdog_off,
   input wire logic serial_periph_on,
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic periph_req,
   input wire logic irq_edge_mode,
   input wire logic irq_flag_clear,
   // mask and flag state
   output logic gmask,
   output logic xmask,
   output logic startup_wait_on,
   output logic irq_flag,
   // cpu control
   output logic cpu_halt,
   output logic stack_req,
   output logic service_nonmask,
   output logic service_irq,
   output logic service_trap,
   output logic resume_next,
   // read cycles while waiting
   output logic bus_read,
   output logic [15:0] bus_addr,
   // clock gating
   output logic osc_run,
   output logic cpu_clk_en,
   output logic timer_clk_en,
   output logic spi_clk_en,
   output logic tx_clk_en,
   output logic rx_clk_en,
   output logic freeze
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      lpw_pkg::lpw_state_t st;
      logic gmask;
      logic xmask;
      logic startup_wait_on;
      logic por_pending;
      logic [lpw_pkg::DELAY_W-1:0] delay_cnt;
      logic wake_x;
      logic wake_irq_svc;
      logic irq_prev;
      logic cpu_halt;
      logic stack_req;
      logic service_nonmask;
      logic service_irq;
      logic service_trap;
      logic resume_next;
      logic bus_read;
      logic [15:0] bus_addr;
      logic osc_run;
      logic cpu_clk_en;
      logic timer_clk_en;
      logic spi_clk_en;
      logic tx_clk_en;
      logic rx_clk_en;
      logic freeze;
   } lpw_regs_t;

   lpw_regs_t r;
   lpw_regs_t next_r;
   logic irq_level_n;
   logic nonmask_level_n;
   logic irq_evt;
   logic irq_flag_q;
   logic irq_request;
   logic irq_active;
   logic nonmask_active;
   logic any_unmasked;

   // ***************************************************************
   // pin synchronisers and maskable flag
   // ***************************************************************
   lpw_sync #(.IDLE(1'b1)) u_sync_irq (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin(irq_req_n_pin),
      .level(irq_level_n)
   );
   lpw_sync #(.IDLE(1'b1)) u_sync_nonmask (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin(nonmask_req_pin_n),
      .level(nonmask_level_n)
   );

   // level mode by default, falling edge only when selected
   assign irq_evt = irq_edge_mode ? (r.irq_prev & ~irq_level_n) : ~irq_level_n;

   lpw_flag u_irq_flag (
      .sys_clk(sys_clk),
      .rst(rst),
      .set_evt(irq_evt),
      .sw_clear(irq_flag_clear),
      .enable(~r.gmask),
      .flag(irq_flag_q),
      .request(irq_request)
   );

   // in level mode the low pin itself is the request; edge mode uses the flag
   assign irq_active = irq_edge_mode ? irq_request : (~irq_level_n & ~r.gmask);
   assign nonmask_active = ~nonmask_level_n;
   assign any_unmasked = irq_active | (nonmask_active & ~r.xmask)
                         | (periph_req & ~r.gmask);

   // ***************************************************************
   // next-state logic
   // ***************************************************************
   always_comb begin
      next_r = r;
      next_r.irq_prev = irq_level_n;
      next_r.stack_req = 1'b0;
      next_r.service_nonmask = 1'b0;
      next_r.service_irq = 1'b0;
      next_r.service_trap = 1'b0;
      next_r.resume_next = 1'b0;
      // software mask updates; hardware sets below win
      if (gmask_clear) begin
         next_r.gmask = 1'b0;
      end
      if (gmask_set) begin
         next_r.gmask = 1'b1;
      end
      // the nonmask bit can only be cleared by software; hardware sets it again on nonmask service
      if (xmask_clear) begin
         next_r.xmask = 1'b0;
      end
      if (startup_wait_clear) begin
         next_r.startup_wait_on = 1'b0;
      end
      case (r.st)
         lpw_pkg::LPW_RUN: begin
            next_r.cpu_halt = 1'b0;
            next_r.bus_read = 1'b0;
            next_r.osc_run = 1'b1;
            next_r.cpu_clk_en = 1'b1;
            next_r.timer_clk_en = 1'b1;
            next_r.spi_clk_en = 1'b1;
            next_r.tx_clk_en = 1'b1;
            next_r.rx_clk_en = 1'b1;
            next_r.freeze = 1'b0;
            if (r.por_pending) begin
               // power-on always pays the restart delay
               next_r.por_pending = 1'b0;
               next_r.st = lpw_pkg::LPW_RESTART;
               next_r.delay_cnt = '0;
               next_r.cpu_halt = 1'b1;
               next_r.wake_x = 1'b0;
               next_r.wake_irq_svc = 1'b0;
            end else if (soft_trap_instr) begin
               // trap runs whatever the masks say and blocks maskable requests; nonmask stays open
               next_r.gmask = 1'b1;
               next_r.service_trap = 1'b1;
            end else if (sleep_instr) begin
               next_r.stack_req = 1'b1;
               next_r.st = lpw_pkg::LPW_STACK;
            end else if (stop_instr && !stop_disable) begin
               next_r.st = lpw_pkg::LPW_STOP;
               next_r.cpu_halt = 1'b1;
               next_r.osc_run = 1'b0;
               next_r.cpu_clk_en = 1'b0;
               next_r.timer_clk_en = 1'b0;
               next_r.spi_clk_en = 1'b0;
               next_r.tx_clk_en = 1'b0;
               next_r.rx_clk_en = 1'b0;
               next_r.freeze = 1'b1;
            end else if (nonmask_active && !r.xmask) begin
               next_r.xmask = 1'b1;
               next_r.gmask = 1'b1;
               next_r.service_nonmask = 1'b1;
            end else if (irq_active) begin
               next_r.gmask = 1'b1;
               next_r.service_irq = 1'b1;
            end
         end
         lpw_pkg::LPW_STACK: begin
            next_r.stack_req = ~stack_done;
            if (stack_done) begin
               next_r.st = lpw_pkg::LPW_WAIT;
               next_r.cpu_halt = 1'b1;
               next_r.cpu_clk_en = 1'b0;
               next_r.bus_read = 1'b1;
               next_r.bus_addr = stacked_flags_addr;
               next_r.osc_run = 1'b1;
               // timer sleeps only when masked and watchdog disabled
               next_r.timer_clk_en = ~(r.gmask & watchdog_off);
               next_r.spi_clk_en = serial_periph_on;
               next_r.tx_clk_en = tx_enable;
               next_r.rx_clk_en = rx_enable;
            end
         end
         lpw_pkg::LPW_WAIT: begin
            next_r.bus_read = 1'b1;
            next_r.timer_clk_en = ~(r.gmask & watchdog_off);
            next_r.spi_clk_en = serial_periph_on;
            next_r.tx_clk_en = tx_enable;
            next_r.rx_clk_en = rx_enable;
            if (any_unmasked) begin
               next_r.st = lpw_pkg::LPW_SERVICE;
               next_r.wake_x = nonmask_active & ~r.xmask;
               next_r.wake_irq_svc = 1'b1;
            end
         end
         lpw_pkg::LPW_STOP: begin
            // low level on the nonmask pin, an unmasked low irq pin, or a pending unmasked edge request
            if (nonmask_active || irq_active || (irq_request && irq_edge_mode)) begin
               next_r.wake_x = nonmask_active;
               next_r.wake_irq_svc = nonmask_active ? ~r.xmask : 1'b1;
               next_r.osc_run = 1'b1;
               next_r.delay_cnt = '0;
               next_r.st = r.startup_wait_on ? lpw_pkg::LPW_RESTART
                                             : lpw_pkg::LPW_SERVICE;
            end
         end
         lpw_pkg::LPW_RESTART: begin
            // counted on the oscillator that has just been restarted
            next_r.osc_run = 1'b1;
            next_r.delay_cnt = lpw_pkg::DELAY_W'(r.delay_cnt + 1'b1);
            if (r.delay_cnt == lpw_pkg::DELAY_LAST) begin
               next_r.st = lpw_pkg::LPW_SERVICE;
            end
         end
         lpw_pkg::LPW_SERVICE: begin
            next_r.st = lpw_pkg::LPW_RUN;
            next_r.cpu_halt = 1'b0;
            next_r.bus_read = 1'b0;
            next_r.freeze = 1'b0;
            next_r.cpu_clk_en = 1'b1;
            next_r.timer_clk_en = 1'b1;
            next_r.spi_clk_en = 1'b1;
            next_r.tx_clk_en = 1'b1;
            next_r.rx_clk_en = 1'b1;
            if (!r.wake_irq_svc) begin
               next_r.resume_next = 1'b1;
            end else if (r.wake_x) begin
               next_r.service_nonmask = 1'b1;
               next_r.xmask = 1'b1;
               next_r.gmask = 1'b1;
            end else if (irq_active || (periph_req && !r.gmask)) begin
               next_r.service_irq = 1'b1;
               next_r.gmask = 1'b1;
            end
         end
         default: begin
            next_r.st = lpw_pkg::LPW_RUN;
         end
      endcase
      // service is ignored by the cpu until it reports done
      if (service_done) begin
         next_r.wake_x = 1'b0;
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   // reset is the full sequence, including wake out of stop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.st <= lpw_pkg::LPW_RUN;
         r.gmask <= lpw_pkg::RST_GMASK;
         r.xmask <= lpw_pkg::RST_XMASK;
         r.startup_wait_on <= lpw_pkg::RST_STARTUP_WAIT_ON;
         r.por_pending <= lpw_pkg::RST_POR_PENDING;
         r.irq_prev <= 1'b1;
         r.osc_run <= 1'b1;
         r.cpu_halt <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign gmask = r.gmask;
   assign xmask = r.xmask;
   assign startup_wait_on = r.startup_wait_on;
   assign irq_flag = irq_flag_q;
   assign cpu_halt = r.cpu_halt;
   assign stack_req = r.stack_req;
   assign service_nonmask = r.service_nonmask;
   assign service_irq = r.service_irq;
   assign service_trap = r.service_trap;
   assign resume_next = r.resume_next;
   assign bus_read = r.bus_read;
   assign bus_addr = r.bus_addr;
   assign osc_run = r.osc_run;
   assign cpu_clk_en = r.cpu_clk_en;
   assign timer_clk_en = r.timer_clk_en;
   assign spi_clk_en = r.spi_clk_en;
   assign tx_clk_en = r.tx_clk_en;
   assign rx_clk_en = r.rx_clk_en;
   assign freeze = r.freeze;
endmodule // lpw_wake_ctrl
`default_nettype wire

// ==== verilog/lpw_end.sv ====
// lpw_end: intentionally empty compilation unit kept last
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/lpw_wake_asserts.sv ====
// lpw_wake_asserts: port-level checks for the wake controller
// assumes it is bound onto lpw_wake_ctrl; one clock, async high reset
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_asserts (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // watched inputs
   input wire logic soft_trap_instr,
   input wire logic stop_instr,
   input wire logic stop_disable,
   input wire logic nonmask_req_pin_n,
   input wire logic watchdog_off,
   input wire logic serial_periph_on,
   input wire logic tx_enable,
   input wire logic rx_enable,
   // watched outputs
   input wire logic gmask,
   input wire logic xmask,
   input wire logic startup_wait_on,
   input wire logic cpu_halt,
   input wire logic service_trap,
   input wire logic service_nonmask,
   input wire logic bus_read,
   input wire logic osc_run,
   input wire logic cpu_clk_en,
   input wire logic timer_clk_en,
   input wire logic spi_clk_en,
   input wire logic tx_clk_en,
   input wire logic rx_clk_en,
   input wire logic freeze
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ****************************************
   // reset, trap, nonmask, wait and stop relations
   // ****************************************
   // gates are registered, so only judge them once the controls have settled
   sequence s_wait_steady;
      bus_read && $past(bus_read)
         && $stable({gmask, watchdog_off, serial_periph_on, tx_enable, rx_enable});
   endsequence
   sequence s_stop_exit;
      !osc_run ##1 (osc_run && startup_wait_on);
   endsequence
   a_reset_masks: assert property ($fell(rst) |-> gmask && xmask && startup_wait_on)
      else $error("masks or delay bit not set after reset");
   a_trap_sets_gmask: assert property (soft_trap_instr && !cpu_halt |-> ##[1:2] (service_trap && gmask))
      else $error("soft trap not serviced or global mask not set");
   a_stop_noop: assert property (stop_instr && stop_disable |=> osc_run [*3])
      else $error("stop taken while disabled");
   a_stop_halts: assert property (!osc_run |-> freeze && !cpu_clk_en && !timer_clk_en
      && !spi_clk_en && !tx_clk_en && !rx_clk_en)
      else $error("clock running in stop");
   a_wait_osc_on: assert property (bus_read |-> osc_run && cpu_halt && !cpu_clk_en)
      else $error("oscillator or cpu wrong in wait");
   a_timer_gate: assert property (s_wait_steady |-> timer_clk_en == !(gmask && watchdog_off))
      else $error("timer gate wrong in wait");
   a_periph_gate: assert property (s_wait_steady |-> spi_clk_en == serial_periph_on
      && tx_clk_en == tx_enable && rx_clk_en == rx_enable)
      else $error("peripheral gate wrong in wait");
   a_nonmask_masks: assert property (service_nonmask |-> ##[0:2] (gmask && xmask))
      else $error("masks not set on nonmask service");
   a_masked_irq_stays: assert property (!osc_run && gmask && nonmask_req_pin_n
      && $past(nonmask_req_pin_n) && $past(nonmask_req_pin_n, 2) |=> !osc_run)
      else $error("stop left while only masked request present");
   a_restart_holds: assert property (s_stop_exit |-> cpu_halt [*8])
      else $error("cpu released during restart delay");
endmodule // lpw_wake_asserts
`default_nettype wire

// ==== verification/lpw_cpu_model.sv ====
// lpw_cpu_model: cpu core stand-in answering register stacking requests
// assumes stack_req is a level from the controller on sys_clk
`timescale 1ns/1ps
`default_nettype none
module lpw_cpu_model #(
   parameter logic [15:0] FLAGS_ADDR = 16'h01F7
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // stacking handshake
   input wire logic stack_req,
   input wire logic slow,
   output logic stack_done,
   output logic [15:0] stacked_flags_addr
);
   logic [3:0] cnt;
   // nine pushes when slow, one when prompt; done is a single pulse
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
         stack_done <= 1'b0;
      end else begin
         stack_done <= stack_req && !stack_done && cnt == (slow ? 4'h8 : 4'h0);
         cnt <= (stack_req && !stack_done) ? cnt + 4'h1 : 4'h0;
      end
   end
   // address only valid with done; inverted otherwise so stale use shows
   assign stacked_flags_addr = stack_done ? FLAGS_ADDR : ~FLAGS_ADDR;
endmodule // lpw_cpu_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the wake controller
// assumes the cpu model file and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp); \
   end \
end
module tb_top;
   logic sys_clk, rst, irq_req_n_pin, nonmask_req_pin_n, stack_done, stop_disable;
   logic watchdog_off, serial_periph_on, tx_enable, rx_enable, periph_req, irq_edge_mode;
   logic soft_trap_instr, sleep_instr, stop_instr, service_done, gmask_clear, gmask_set;
   logic xmask_clear, startup_wait_clear, irq_flag_clear, slow;
   logic gmask, xmask, startup_wait_on, irq_flag, cpu_halt, stack_req, service_nonmask;
   logic service_irq, service_trap, resume_next, bus_read, osc_run, cpu_clk_en;
   logic timer_clk_en, spi_clk_en, tx_clk_en, rx_clk_en, freeze;
   logic [15:0] bus_addr, stacked_flags_addr;
   logic [8:0] stb;
   logic [3:0] seen;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   assign {service_done, irq_flag_clear, startup_wait_clear, xmask_clear, gmask_set,
      gmask_clear, stop_instr, sleep_instr, soft_trap_instr} = stb;
   lpw_wake_ctrl lpw_wake_ctrl_i (.sys_clk, .rst, .irq_req_n_pin, .nonmask_req_pin_n,
      .soft_trap_instr, .sleep_instr, .stop_instr, .stack_done, .service_done,
      .stop_disable, .stacked_flags_addr, .gmask_clear, .gmask_set, .xmask_clear,
      .startup_wait_clear, .watchdog_off, .serial_periph_on, .tx_enable, .rx_enable,
      .periph_req, .irq_edge_mode, .irq_flag_clear, .gmask, .xmask, .startup_wait_on,
      .irq_flag, .cpu_halt, .stack_req, .service_nonmask, .service_irq, .service_trap,
      .resume_next, .bus_read, .bus_addr, .osc_run, .cpu_clk_en, .timer_clk_en,
      .spi_clk_en, .tx_clk_en, .rx_clk_en, .freeze);
   lpw_cpu_model lpw_cpu_model_i (.sys_clk, .rst, .stack_req, .slow, .stack_done,
      .stacked_flags_addr);
   // 25 ns period
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // sticky record of one-cycle answers: {resume, nonmask service, irq, swi}
   always @(posedge sys_clk) begin
      seen <= seen | {resume_next, service_nonmask, service_irq, service_trap};
      cycles++;
      if (cycles == 16000) begin
         fails++;
         wrap_up();
      end
   end
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic pulse(input logic [8:0] m);
      @(negedge sys_clk) stb = m;
      @(negedge sys_clk) stb = 9'h000;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // bounded wait: sel 0 for cpu release, 1 for wait entry; n counts cycles
   task automatic hold(input int sel, input int lim, output int n);
      n = 0;
      while (((sel == 0) ? cpu_halt : !bus_read) !== 1'b0 && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      int n;
      `CHK({gmask, xmask, startup_wait_on}, 3'b111)
      hold(0, 5000, n);
      `CHK(n >= 4096, 1'b1)
      $display("test reset done");
   endtask
   task automatic t_trap;
      pulse(9'h020);
      seen = 4'h0;
      pulse(9'h001);
      idle(3);
      `CHK(seen, 4'h1)
      `CHK(gmask, 1'b1)
      pulse(9'h008);
      idle(2);
      pulse(9'h001);
      idle(3);
      `CHK(gmask, 1'b1)
      $display("test trap done");
   endtask
   task automatic t_wait;
      int n;
      periph_req = 1'b1;
      pulse(9'h002);
      hold(1, 40, n);
      idle(2);
      `CHK(bus_addr, 16'h01F7)
      `CHK({osc_run, cpu_clk_en, timer_clk_en}, 3'b100)
      `CHK({spi_clk_en, tx_clk_en, rx_clk_en}, 3'b101)
      watchdog_off = 1'b0;
      idle(10);
      `CHK({bus_read, timer_clk_en}, 2'b11)
      watchdog_off = 1'b1;
      seen = 4'h0;
      nonmask_req_pin_n = 1'b0;
      hold(0, 20, n);
      nonmask_req_pin_n = 1'b1;
      periph_req = 1'b0;
      idle(2);
      `CHK(seen, 4'h4)
      `CHK({gmask, xmask}, 2'b11)
      $display("test wait done");
   endtask
   task automatic t_stop;
      int n;
      stop_disable = 1'b1;
      pulse(9'h004);
      idle(3);
      `CHK(osc_run, 1'b1)
      stop_disable = 1'b0;
      pulse(9'h040);
      idle(2);
      `CHK(startup_wait_on, 1'b0)
      pulse(9'h004);
      irq_req_n_pin = 1'b0;
      idle(10);
      `CHK({osc_run, freeze, cpu_clk_en}, 3'b010)
      irq_req_n_pin = 1'b1;
      seen = 4'h0;
      nonmask_req_pin_n = 1'b0;
      hold(0, 20, n);
      nonmask_req_pin_n = 1'b1;
      idle(2);
      `CHK(seen, 4'h8)
      pulse(9'h008);
      pulse(9'h004);
      idle(4);
      seen = 4'h0;
      irq_req_n_pin = 1'b0;
      hold(0, 20, n);
      irq_req_n_pin = 1'b1;
      idle(2);
      `CHK({seen, gmask}, 5'h05)
      $display("test stop done");
   endtask
   task automatic t_reset_stop;
      int n;
      pulse(9'h004);
      idle(3);
      rst = 1'b1;
      idle(2);
      `CHK({gmask, xmask, startup_wait_on, osc_run}, 4'hF)
      rst = 1'b0;
      hold(0, 5000, n);
      `CHK(n >= 4096, 1'b1)
      // nonmask enabled, delay bit set again by reset: wake pays delay, then service
      pulse(9'h020);
      pulse(9'h004);
      seen = 4'h0;
      nonmask_req_pin_n = 1'b0;
      hold(0, 5000, n);
      nonmask_req_pin_n = 1'b1;
      idle(2);
      `CHK(n >= 4096, 1'b1)
      `CHK(seen, 4'h4)
      $display("test reset in stop done");
   endtask
   task automatic t_flag;
      irq_edge_mode = 1'b1;
      irq_req_n_pin = 1'b0;
      idle(4);
      irq_req_n_pin = 1'b1;
      idle(5);
      `CHK(irq_flag, 1'b1)
      pulse(9'h080);
      pulse(9'h100);
      idle(2);
      `CHK(irq_flag, 1'b0)
      $display("test flag done");
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      stb = 9'h000;
      seen = 4'h0;
      slow = 1'b1;
      irq_req_n_pin = 1'b1;
      nonmask_req_pin_n = 1'b1;
      stop_disable = 1'b0;
      watchdog_off = 1'b1;
      serial_periph_on = 1'b1;
      tx_enable = 1'b0;
      rx_enable = 1'b1;
      periph_req = 1'b0;
      irq_edge_mode = 1'b0;
      idle(6);
      rst = 1'b0;
      t_reset();
      t_trap();
      t_wait();
      t_stop();
      t_reset_stop();
      t_flag();
      wrap_up();
   end
endmodule // tb_top
bind lpw_wake_ctrl lpw_wake_asserts lpw_wake_asserts_i (.sys_clk, .rst, .soft_trap_instr,
   .stop_instr, .stop_disable, .nonmask_req_pin_n, .watchdog_off, .serial_periph_on,
   .tx_enable, .rx_enable, .gmask, .xmask, .startup_wait_on, .cpu_halt, .service_trap,
   .service_nonmask, .bus_read, .osc_run, .cpu_clk_en, .timer_clk_en, .spi_clk_en,
   .tx_clk_en, .rx_clk_en, .freeze);
`default_nettype wire
